// ==== rtl/pog_pkg.sv ====
// Purpose: shared constants and types of the protection output alarm gate
// Assumes: 100 MHz core clock, 16-bit parameter map words
// Notes: alarm flag n of the input vector is alarm number n+1
package pog_pkg;
   // clock and time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int SECOND_MS = 1000;
   localparam int NS_PER_MS = 1000000;
   localparam int SEC_CYCLES_DFLT = SECOND_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int CNT_W = 32;
   // parameter map locations
   localparam int ADDR_W = 8;
   localparam int WORD_W = 16;
   localparam logic [7:0] CFG_ADDR = 8'h11;
   localparam logic [7:0] STATUS_ADDR = 8'h26;
   // configuration word layout
   localparam int MASK_W = 12;
   localparam int DLY_LSB = 12;
   localparam int DLY_W = 4;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   // enable weights of the alarms that may act on the output
   localparam int OVERVOLT_BIT = 1;
   localparam int UNDERVOLT_BIT = 2;
   localparam int SHORT_BIT = 3;
   localparam int EXC_OC_BIT = 4;
   localparam int UNDERSPEED_BIT = 5;
   localparam int OVERSPEED_BIT = 6;
   localparam logic [11:0] ENABLE_MASK = 12'h07e;
   // status word layout
   localparam int ALARM_N = 7;
   localparam int HEALTHY_BIT = 11;
   localparam int OPTIME_W = 32;
   localparam logic [15:0] ZERO_WORD = 16'h0000;

   typedef enum logic [1:0] {
      DLY_IDLE,
      DLY_COUNT,
      DLY_CLOSED
   } pog_dly_state_e;

   // true when one of alarm flags 1 to 6 is active with its enable bit set
   function automatic logic pog_enabled(input logic [ALARM_N-1:0] alarms,
                                        input logic [WORD_W-1:0] cfg);
      logic [MASK_W-1:0] vec;
      vec = {{(MASK_W-ALARM_N){1'b0}}, alarms};
      return |(vec & cfg[MASK_W-1:0] & ENABLE_MASK);
   endfunction
endpackage

// ==== rtl/pog_ctl_if.sv ====
// Purpose: control signals between the gate top and its timers
// Assumes: all signals in the core_clk domain
// Notes: every signal is driven from a flip-flop
interface pog_ctl_if;
   import pog_pkg::*;
   logic armed;
   logic [DLY_W-1:0] delay_s;
   logic closing;
   logic healthy;
   logic [OPTIME_W-1:0] op_time;
   logic op_store;
   modport top (output armed, output delay_s, output healthy,
                input closing, input op_time, input op_store);
   modport dly (input armed, input delay_s, output closing);
   modport opt (input healthy, output op_time, output op_store);
endinterface

// ==== rtl/pog_delay.sv ====
// Purpose: whole-second activation delay for the protection output
// Assumes: armed is a registered level
// Notes: the count restarts whenever armed drops
module pog_delay import pog_pkg::*; #(
   parameter int SEC_CYCLES = SEC_CYCLES_DFLT
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // control
   pog_ctl_if.dly ctl
);
   pog_dly_state_e state_q, state_d;
   logic [CNT_W-1:0] cyc_q, cyc_d;
   logic [DLY_W-1:0] sec_q, sec_d;
   logic closing_q, closing_d;

   always_comb begin
      state_d = state_q;
      cyc_d = cyc_q;
      sec_d = sec_q;
      unique case (state_q)
         DLY_IDLE: begin
            cyc_d = '0;
            sec_d = '0;
            if (ctl.armed) begin
               state_d = (ctl.delay_s == '0) ? DLY_CLOSED : DLY_COUNT; // see R2
            end
         end
         DLY_COUNT: begin
            if (!ctl.armed) begin
               state_d = DLY_IDLE; // see R12
            end else if (cyc_q == CNT_W'(SEC_CYCLES - 1)) begin
               cyc_d = '0;
               sec_d = sec_q + 1'b1;
               if ((sec_q + 1'b1) >= ctl.delay_s) begin
                  state_d = DLY_CLOSED; // see R2
               end
            end else begin
               cyc_d = cyc_q + 1'b1;
            end
         end
         DLY_CLOSED: begin
            if (!ctl.armed) begin
               state_d = DLY_IDLE; // see R12
            end
         end
      endcase
      closing_d = (state_d == DLY_CLOSED);
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state_q <= DLY_IDLE;
         cyc_q <= '0;
         sec_q <= '0;
         closing_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cyc_q <= cyc_d;
         sec_q <= sec_d;
         closing_q <= closing_d;
      end
   end

   assign ctl.closing = closing_q;
endmodule

// ==== rtl/pog_optime.sv ====
// Purpose: operating time counter and record store on first alarm
// Assumes: healthy is a registered level
// Notes: counter saturates at full scale
module pog_optime import pog_pkg::*; #(
   parameter int SEC_CYCLES = SEC_CYCLES_DFLT
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // control
   pog_ctl_if.opt ctl
);
   logic [CNT_W-1:0] tick_q, tick_d;
   logic [OPTIME_W-1:0] secs_q, secs_d;
   logic [OPTIME_W-1:0] rec_q, rec_d;
   logic store_q, store_d;
   logic prev_q, prev_d;

   always_comb begin
      tick_d = tick_q + 1'b1;
      secs_d = secs_q;
      if (tick_q == CNT_W'(SEC_CYCLES - 1)) begin
         tick_d = '0;
         if (secs_q != '1) begin
            secs_d = secs_q + 1'b1;
         end
      end
      prev_d = ctl.healthy;
      store_d = prev_q && !ctl.healthy; // see R10
      rec_d = store_d ? secs_q : rec_q; // see R10
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         tick_q <= '0;
         secs_q <= '0;
         rec_q <= '0;
         store_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         tick_q <= tick_d;
         secs_q <= secs_d;
         rec_q <= rec_d;
         store_q <= store_d;
         prev_q <= prev_d;
      end
   end

   assign ctl.op_time = rec_q;
   assign ctl.op_store = store_q;
endmodule

// ==== rtl/pog_top.sv ====
// Purpose: alarm driven protection output with parameter map access
// Assumes: alarm flags and parameter strobes synchronous to core_clk
// Notes: open collector output, transistor conducts while oe_n is low
// Operation
// R1 - output transistor open normally, closed only with an enabled alarm active
// R2 - closing postponed by 0 to 15 whole seconds from enabled alarm onset
// R3 - only the enable bits of the configuration word select acting alarms
// R4 - output open with no alarm, or with active alarms all disabled
// R5 - configuration word: enable mask low bits, delay seconds in bits 15:12
// R6 - over-voltage enable is bit 1, overspeed enable is bit 6
// R7 - under-voltage 2, short 3, excitation 4, underspeed 5; bits 7-11 inert
// R8 - software writes delay times 4096 plus summed alarm weights
// R9 - with no alarm the healthy flag is set, status bit 11 reads one
// R10 - any alarm clears healthy flag and bit 11, stores operating time
// R11 - status bit n reports alarm number n plus one
// R12 - delay restarts and output reopens once no enabled alarm remains
module pog_top import pog_pkg::*; #(
   parameter int SEC_CYCLES = SEC_CYCLES_DFLT
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // alarm flags, bit n is alarm n+1
   input wire logic [ALARM_N-1:0] alarm_flags,
   // parameter map port
   input wire logic par_wr,
   input wire logic par_rd,
   input wire logic [ADDR_W-1:0] par_addr,
   input wire logic [WORD_W-1:0] par_wdata,
   output logic [WORD_W-1:0] par_rdata,
   output logic par_rvalid,
   // protection output pin
   input wire logic protection_output_in,
   output logic protection_output_out,
   output logic protection_output_oe_n,
   // healthy flag and operating time record
   output logic healthy_flag,
   output logic [OPTIME_W-1:0] operating_time_record,
   output logic operating_time_store
);
   pog_ctl_if ctl ();

   logic [WORD_W-1:0] cfg_q, cfg_d;
   logic [ALARM_N-1:0] alarm_q, alarm_d;
   logic healthy_q, healthy_d;
   logic armed_q, armed_d;
   logic oe_n_q, oe_n_d;
   logic [WORD_W-1:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic pin_q, pin_d;
   logic [WORD_W-1:0] status_word;
   logic en_act;

   // enabled alarm decode and status state
   always_comb begin
      en_act = pog_enabled(alarm_flags, cfg_q); // see R3 see R6 see R7
      armed_d = en_act; // see R1 see R4
      alarm_d = alarm_flags; // see R11
      healthy_d = (alarm_flags == '0); // see R9 see R10
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         armed_q <= 1'b0;
         alarm_q <= '0;
         healthy_q <= 1'b0;
      end else begin
         armed_q <= armed_d;
         alarm_q <= alarm_d;
         healthy_q <= healthy_d;
      end
   end

   // protection output driver
   always_comb begin
      oe_n_d = !ctl.closing; // see R1 see R12
      pin_d = 1'b0;
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         oe_n_q <= 1'b1;
         pin_q <= 1'b0;
      end else begin
         oe_n_q <= oe_n_d;
         pin_q <= pin_d;
      end
   end

   // status word view
   always_comb begin
      status_word = ZERO_WORD;
      status_word[ALARM_N-1:0] = alarm_q; // see R11
      status_word[HEALTHY_BIT] = healthy_q; // see R9 see R10
   end

   // parameter map access
   always_comb begin
      cfg_d = cfg_q;
      if (par_wr && par_addr == CFG_ADDR) begin
         cfg_d = par_wdata; // see R5 see R8
      end
      rvalid_d = par_rd;
      rdata_d = ZERO_WORD;
      if (par_rd) begin
         if (par_addr == CFG_ADDR) begin
            rdata_d = cfg_q;
         end else if (par_addr == STATUS_ADDR) begin
            rdata_d = status_word;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         cfg_q <= CFG_RESET;
         rdata_q <= ZERO_WORD;
         rvalid_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // timers
   assign ctl.armed = armed_q;
   assign ctl.delay_s = cfg_q[DLY_LSB +: DLY_W]; // see R5
   assign ctl.healthy = healthy_q;

   pog_delay #(
      .SEC_CYCLES(SEC_CYCLES)
   ) u_delay (
      .core_clk(core_clk),
      .resetn(resetn),
      .ctl(ctl.dly)
   );

   pog_optime #(
      .SEC_CYCLES(SEC_CYCLES)
   ) u_optime (
      .core_clk(core_clk),
      .resetn(resetn),
      .ctl(ctl.opt)
   );

   // outputs
   assign par_rdata = rdata_q;
   assign par_rvalid = rvalid_q;
   assign protection_output_out = pin_q;
   assign protection_output_oe_n = oe_n_q;
   assign healthy_flag = healthy_q;
   assign operating_time_record = ctl.op_time;
   assign operating_time_store = ctl.op_store;

   // assertion helper: cycles the enabled alarm has stood
   localparam int CLOSE_LAT = 2;
   logic [CNT_W-1:0] armed_cyc_q, armed_cyc_d;
   logic [CNT_W-1:0] dly_cyc;

   always_comb begin
      armed_cyc_d = armed_cyc_q;
      if (!armed_q) begin
         armed_cyc_d = '0;
      end else if (armed_cyc_q != '1) begin
         armed_cyc_d = armed_cyc_q + 1'b1;
      end
      dly_cyc = CNT_W'(ctl.delay_s) * CNT_W'(SEC_CYCLES);
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         armed_cyc_q <= '0;
      end else begin
         armed_cyc_q <= armed_cyc_d;
      end
   end

   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   chk_open_no_alarm: assert property ( // see R4
      (alarm_flags == '0) [*3] |=> protection_output_oe_n)
      else $error("output closed without any alarm");

   chk_open_unmasked: assert property ( // see R3
      ((cfg_q[MASK_W-1:0] & ENABLE_MASK) == '0) [*3] |=> protection_output_oe_n)
      else $error("output closed with no alarm enabled");

   chk_closed_only_armed: assert property ( // see R1
      !protection_output_oe_n |-> $past(armed_q, 2))
      else $error("output closed without an enabled alarm");

   chk_zero_delay: assert property ( // see R2
      (en_act && cfg_q[DLY_LSB +: DLY_W] == '0) [*3] |=> !protection_output_oe_n)
      else $error("zero delay did not close output in time");

   chk_delay_holds: assert property ( // see R2
      (SEC_CYCLES >= 8 && $rose(armed_q) && ctl.delay_s != '0)
      |-> protection_output_oe_n [*8])
      else $error("output closed before the programmed delay");

   chk_overspeed_arms: assert property ( // see R6
      (alarm_flags[OVERSPEED_BIT] && cfg_q[OVERSPEED_BIT]) |=> armed_q)
      else $error("overspeed enable did not arm output");

   chk_overvolt_arms: assert property ( // see R6
      (alarm_flags[OVERVOLT_BIT] && cfg_q[OVERVOLT_BIT]) |=> armed_q)
      else $error("over-voltage enable did not arm output");

   chk_reopen_clear: assert property ( // see R12
      $fell(armed_q) |-> ##2 protection_output_oe_n)
      else $error("output did not reopen after alarms cleared");

   chk_healthy_set: assert property ( // see R9
      (alarm_flags == '0) ##1 par_rd && par_addr == STATUS_ADDR
      |=> par_rdata[HEALTHY_BIT] && $past(healthy_flag))
      else $error("healthy bit not set with no alarm");

   chk_healthy_clear: assert property ( // see R10
      (alarm_flags != '0)
      |=> !healthy_flag ##1 (operating_time_store == $past(healthy_flag, 2)))
      else $error("alarm did not clear healthy flag");

   chk_time_store: assert property ( // see R10
      $fell(healthy_flag) |=> operating_time_store ##1 !operating_time_store)
      else $error("operating time not stored on first alarm");

   chk_status_bits: assert property ( // see R11
      par_rd && par_addr == STATUS_ADDR |=> par_rdata[ALARM_N-1:0] == $past(alarm_q))
      else $error("status bits do not follow alarm flags");

   chk_cfg_write: assert property ( // see R5
      par_wr && par_addr == CFG_ADDR ##1 par_rd && par_addr == CFG_ADDR && !par_wr
      |=> par_rdata == $past(par_wdata, 2))
      else $error("configuration word readback mismatch");

   chk_delay_full: assert property ( // see R2
      armed_q && armed_cyc_q != '0 && armed_cyc_q < dly_cyc
      |-> protection_output_oe_n)
      else $error("output closed before the full programmed delay");

   chk_delay_close: assert property ( // see R2
      armed_q && armed_cyc_q == dly_cyc + CNT_W'(CLOSE_LAT)
      |-> !protection_output_oe_n)
      else $error("output not closed when the delay ran out");

   chk_closed_holds: assert property ( // see R1
      !protection_output_oe_n && armed_q && $past(armed_q)
      |=> !protection_output_oe_n)
      else $error("output opened while an enabled alarm stands");

   chk_undervolt_arms: assert property ( // see R7
      (alarm_flags[UNDERVOLT_BIT] && cfg_q[UNDERVOLT_BIT])
      |=> armed_q)
      else $error("under-voltage enable did not arm output");

   chk_short_arms: assert property ( // see R7
      (alarm_flags[SHORT_BIT] && cfg_q[SHORT_BIT])
      |=> armed_q)
      else $error("short circuit enable did not arm output");

   chk_exc_oc_arms: assert property ( // see R7
      (alarm_flags[EXC_OC_BIT] && cfg_q[EXC_OC_BIT])
      |=> armed_q)
      else $error("excitation overcurrent enable did not arm output");

   chk_underspeed_arms: assert property ( // see R7
      (alarm_flags[UNDERSPEED_BIT] && cfg_q[UNDERSPEED_BIT])
      |=> armed_q)
      else $error("underspeed enable did not arm output");

   chk_inert_bits: assert property ( // see R7
      ((cfg_q[MASK_W-1:0] & ENABLE_MASK) == '0)
      |=> !armed_q)
      else $error("inert enable bits armed the output");

   chk_disarm_all: assert property ( // see R4
      ((alarm_flags[OVERSPEED_BIT:OVERVOLT_BIT] & cfg_q[OVERSPEED_BIT:OVERVOLT_BIT]) == '0)
      |=> !armed_q)
      else $error("output armed with every active alarm disabled");

   chk_cfg_only: assert property ( // see R5
      par_wr && par_addr != CFG_ADDR
      |=> $stable(cfg_q))
      else $error("configuration changed by a write elsewhere");

   chk_healthy_hold: assert property ( // see R9
      (alarm_flags == '0)
      |=> healthy_flag)
      else $error("healthy flag low with no alarm");

   chk_status_healthy: assert property ( // see R9
      par_rd && par_addr == STATUS_ADDR
      |=> par_rdata[HEALTHY_BIT] == $past(healthy_flag))
      else $error("status healthy bit does not follow the flag");

   chk_status_spare: assert property ( // see R11
      par_rd && par_addr == STATUS_ADDR
      |=> par_rdata[WORD_W-1:HEALTHY_BIT+1] == '0 && par_rdata[HEALTHY_BIT-1:ALARM_N] == '0)
      else $error("spare status bits not zero");

   chk_store_once: assert property ( // see R10
      operating_time_store
      |=> !operating_time_store)
      else $error("time store pulse longer than one cycle");

   chk_record_hold: assert property ( // see R10
      !operating_time_store
      |-> $stable(operating_time_record))
      else $error("time record changed without a store");
endmodule

// ==== dv/pog_relay_model.sv ====
// Purpose: isolating relay on the open collector protection output
// Assumes: pull-up on the relay side of the pin
// Notes: contact closes while the transistor conducts
module pog_relay_model (
   // pin side
   input wire logic oe_n,
   input wire logic drive,
   output logic pin_level,
   // contact state
   output logic contact_closed
);
   timeunit 1ns;
   timeprecision 100ps;
   // pull-up wins while the transistor is off
   assign pin_level = oe_n ? 1'b1 : drive;
   assign contact_closed = ~pin_level;
endmodule

// ==== dv/tb_protection_output_alarm_gate.sv ====
// Purpose: self-checking bench of the protection output alarm gate
// Assumes: one second shortened to SEC cycles
// Notes: inputs driven 1 ns after the rising edge
module tb_protection_output_alarm_gate import pog_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int SEC = 16;
   logic core_clk, resetn, par_wr, par_rd, par_rvalid;
   logic [ADDR_W-1:0] par_addr;
   logic [WORD_W-1:0] par_wdata, par_rdata;
   logic [ALARM_N-1:0] alarm_flags;
   logic pin_level, oe_out, oe_n, healthy, store, contact;
   logic [OPTIME_W-1:0] rec;
   int fails = 0;
   int checks_done = 0;
   int since_rel = 0;
   int n;
   int dl [3] = '{2, 15, 2};

   pog_top #(.SEC_CYCLES(SEC)) dut (.core_clk(core_clk), .resetn(resetn),
      .alarm_flags(alarm_flags), .par_wr(par_wr), .par_rd(par_rd), .par_addr(par_addr),
      .par_wdata(par_wdata), .par_rdata(par_rdata), .par_rvalid(par_rvalid),
      .protection_output_in(pin_level), .protection_output_out(oe_out),
      .protection_output_oe_n(oe_n), .healthy_flag(healthy),
      .operating_time_record(rec), .operating_time_store(store));
   pog_relay_model relay (.oe_n(oe_n), .drive(oe_out), .pin_level(pin_level),
      .contact_closed(contact));

   always @(posedge core_clk) begin
      since_rel <= resetn ? since_rel + 1 : 0;
   end

   task automatic final_report();
      $display("checks_done %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      par_wr = 1'b1;
      par_addr = a;
      par_wdata = d;
      cyc(1);
      par_wr = 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
      par_rd = 1'b1;
      par_addr = a;
      cyc(1);
      par_rd = 1'b0;
      chk("rvalid", 1, par_rvalid);
      chk(what, exp, par_rdata);
      cyc(1);
      chk("rvalid end", 0, par_rvalid);
   endtask

   task automatic wait_oe(input logic v, input int bound, output int k);
      k = 0;
      while (oe_n !== v && k < bound) begin
         cyc(1);
         k++;
      end
      if (oe_n !== v) begin
         fails++;
         $display("MISMATCH oe_n wait expected %h seen %h", v, oe_n);
         final_report();
      end
   endtask

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   initial begin
      resetn = 1'b0;
      par_wr = 1'b0;
      par_rd = 1'b0;
      par_addr = 8'h00;
      par_wdata = 16'h0000;
      alarm_flags = 7'h00;
      cyc(16);
      resetn = 1'b1;
      cyc(2);
      chk("oe_n idle", 1, oe_n);
      chk("healthy", 1, healthy);
      rd_chk(CFG_ADDR, 16'h0000, "cfg reset");
      rd_chk(STATUS_ADDR, 16'h0800, "status ok");
      wr(STATUS_ADDR, 16'hffff);
      rd_chk(STATUS_ADDR, 16'h0800, "status ro");
      rd_chk(8'h12, 16'h0000, "unmapped");
      cyc(2 * SEC);
      // first alarm: healthy drops, time record stored
      alarm_flags = 7'h30;
      cyc(1);
      chk("healthy drop", 0, healthy);
      chk("store early", 0, store);
      cyc(1);
      chk("store", 1, store);
      chk("record", 32'((since_rel - 1) / SEC), rec);
      cyc(1);
      chk("store end", 0, store);
      rd_chk(STATUS_ADDR, 16'h0030, "status alarms");
      chk("oe_n cfg zero", 1, oe_n);
      // inert and disabled enables leave the output open
      wr(CFG_ADDR, 16'h0f81);
      rd_chk(CFG_ADDR, 16'h0f81, "cfg readback");
      alarm_flags = 7'h7f;
      cyc(8);
      chk("oe_n inert", 1, oe_n);
      wr(CFG_ADDR, 16'h007c);
      alarm_flags = 7'h03;
      cyc(8);
      chk("oe_n disabled", 1, oe_n);
      alarm_flags = 7'h00;
      cyc(3);
      // each acting alarm alone, zero delay
      for (int b = 1; b < 7; b++) begin
         wr(CFG_ADDR, 16'h0001 << b);
         alarm_flags = 7'h01 << b;
         wait_oe(1'b0, 10, n);
         chk("close lat", 3, n);
         chk("contact", 1, contact);
         chk("out low", 0, oe_out);
         alarm_flags = 7'h00;
         wait_oe(1'b1, 10, n);
         chk("open lat", 3, n);
         cyc(2);
      end
      // delayed closing, last pass drops the alarm mid count
      for (int i = 0; i < 3; i++) begin
         wr(CFG_ADDR, (16'(dl[i]) << DLY_LSB) | 16'h0020);
         alarm_flags = 7'h20;
         if (i == 2) begin
            cyc(20);
            alarm_flags = 7'h00;
            cyc(1);
            alarm_flags = 7'h20;
         end
         wait_oe(1'b0, 300, n);
         chk("delay", 1, n >= 1 + dl[i] * SEC && n <= 5 + dl[i] * SEC);
         alarm_flags = 7'h00;
         wait_oe(1'b1, 10, n);
         chk("reopen lat", 3, n);
         cyc(2);
      end
      // second reset restores the configuration
      resetn = 1'b0;
      cyc(2);
      resetn = 1'b1;
      cyc(1);
      chk("healthy rst2", 1, healthy);
      rd_chk(CFG_ADDR, 16'h0000, "cfg after reset");
      final_report();
   end
endmodule
